// [verilog/uif_ctrl.sv]
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module uif_ctrl
    import uif_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic line_status_pend,
    input wire logic rx_available_pend,
    input wire logic char_timeout_pend,
    input wire logic tx_empty_pend,
    input wire logic modem_status_pend,
    input wire logic busy_detect_pend,
    output logic dma_signal_mode,
    output logic fifo_enable_both,
    output logic tx_fifo_clear,
    output logic rx_fifo_clear,
    output logic [3:0] interrupt_ident_code,
    output logic irq
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic do_write;
    logic lane0;
    logic [3:0] source_enable;
    logic [EV_WIDTH-1:0] event_status;
    logic [EV_WIDTH-1:0] event_mask;
    logic [EV_WIDTH-1:0] event_set;
    logic [EV_WIDTH-1:0] event_clr;
    logic [3:0] next_code;
    logic ctrl_write;
    logic enable_flip;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    // ----------------------------------------------------------------
    // write channel
    // ----------------------------------------------------------------
    // address and data are latched separately so either may come first
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign lane0 = w_strb[0];
    assign ctrl_write = do_write && lane0 && (aw_addr == ADDR_IRQ_IDENT_FIFO_CONTROL);

    // ready drops at the handshake, so only one write is ever outstanding
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    // data slot freed only with the response, same as the address side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // unmapped offsets still get an answer, so a stray write cannot hang the master
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bresp <= RESP_OKAY;
        end else if (do_write) begin
            if (aw_addr == ADDR_IRQ_IDENT_FIFO_CONTROL || aw_addr == ADDR_IRQ_SOURCE_ENABLE ||
                aw_addr == ADDR_EVENT_STATUS || aw_addr == ADDR_EVENT_MASK ||
                aw_addr == ADDR_BLOCK_STATE) begin
                s_axi_bresp <= RESP_OKAY;
            end else begin
                s_axi_bresp <= RESP_SLVERR;
            end
        end
    end

    // ----------------------------------------------------------------
    // fifo control
    // ----------------------------------------------------------------
    assign enable_flip = ctrl_write && (w_data[BIT_FIFO_ENABLE] != fifo_enable_both);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dma_signal_mode <= RST_DMA_MODE;
        end else if (ctrl_write) begin
            dma_signal_mode <= w_data[BIT_DMA_MODE];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fifo_enable_both <= RST_FIFO_ENABLE;
        end else if (ctrl_write) begin
            fifo_enable_both <= w_data[BIT_FIFO_ENABLE];
        end
    end

    // clears are one-cycle pulses, so nothing is left for software to undo
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_fifo_clear <= 1'b0;
        end else begin
            tx_fifo_clear <= (ctrl_write && w_data[BIT_TX_FIFO_CLEAR]) || enable_flip;
        end
    end

    // kept apart so either side can be cleared alone
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_fifo_clear <= 1'b0;
        end else begin
            rx_fifo_clear <= (ctrl_write && w_data[BIT_RX_FIFO_CLEAR]) || enable_flip;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            source_enable <= RST_SOURCE_ENABLE;
        end else if (do_write && lane0 && aw_addr == ADDR_IRQ_SOURCE_ENABLE) begin
            source_enable <= w_data[3:0];
        end
    end

    // ----------------------------------------------------------------
    // interrupt identification
    // ----------------------------------------------------------------
    uif_ident_enc u_enc (
        .line_status_pend(line_status_pend),
        .rx_available_pend(rx_available_pend),
        .char_timeout_pend(char_timeout_pend),
        .tx_empty_pend(tx_empty_pend),
        .modem_status_pend(modem_status_pend),
        .busy_detect_pend(busy_detect_pend),
        .source_enable(source_enable),
        .fifo_enable(fifo_enable_both),
        .code(next_code)
    );

    // one cycle of latency from a source to the code
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            interrupt_ident_code <= IID_NONE;
        end else begin
            interrupt_ident_code <= next_code;
        end
    end

    // ----------------------------------------------------------------
    // events and interrupt output
    // ----------------------------------------------------------------
    always_comb begin
        event_set = '0;
        event_set[EV_TX_CLEARED] = tx_fifo_clear;
        event_set[EV_RX_CLEARED] = rx_fifo_clear;
        event_set[EV_ENABLE_CHANGED] = enable_flip;
        event_set[EV_IRQ_RAISED] = (interrupt_ident_code == IID_NONE) && (next_code != IID_NONE);
    end

    assign event_clr = (do_write && lane0 && aw_addr == ADDR_EVENT_STATUS) ? w_data[EV_WIDTH-1:0] : '0;

    // a set in the clearing cycle wins, so no event is lost
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_status <= RST_EVENT;
        end else begin
            event_status <= (event_status & ~event_clr) | event_set;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_mask <= RST_EVENT;
        end else if (do_write && lane0 && aw_addr == ADDR_EVENT_MASK) begin
            event_mask <= w_data[EV_WIDTH-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((event_status & ~event_clr) | event_set) & event_mask);
        end
    end

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    // reads only select data; the fifo controls are never touched here
    always_comb begin
        next_rdata = 32'h0;
        next_rresp = RESP_OKAY;
        case (s_axi_araddr)
            ADDR_IRQ_IDENT_FIFO_CONTROL: next_rdata[3:0] = interrupt_ident_code;
            ADDR_IRQ_SOURCE_ENABLE: next_rdata[3:0] = source_enable;
            ADDR_EVENT_STATUS: next_rdata[EV_WIDTH-1:0] = event_status;
            ADDR_EVENT_MASK: next_rdata[EV_WIDTH-1:0] = event_mask;
            ADDR_BLOCK_STATE: next_rdata[7:0] = {busy_detect_pend, modem_status_pend, tx_empty_pend,
                char_timeout_pend, rx_available_pend, line_status_pend, dma_signal_mode, fifo_enable_both};
            default: next_rresp = RESP_SLVERR;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // decoded at the handshake edge, then held while rvalid waits for rready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

endmodule

// [verilog/uif_pkg.sv]
package uif_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_IRQ_IDENT_FIFO_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_IRQ_SOURCE_ENABLE = 8'h04;
    localparam logic [7:0] ADDR_EVENT_STATUS = 8'h08;
    localparam logic [7:0] ADDR_EVENT_MASK = 8'h0c;
    localparam logic [7:0] ADDR_BLOCK_STATE = 8'h10;

    // ----------------------------------------------------------------
    // control field positions
    // ----------------------------------------------------------------
    localparam int BIT_DMA_MODE = 3;
    localparam int BIT_TX_FIFO_CLEAR = 2;
    localparam int BIT_RX_FIFO_CLEAR = 1;
    localparam int BIT_FIFO_ENABLE = 0;

    // source enable field positions
    localparam int BIT_RX_AVAILABLE_EN = 0;
    localparam int BIT_TX_EMPTY_EN = 1;
    localparam int BIT_LINE_STATUS_EN = 2;
    localparam int BIT_MODEM_STATUS_EN = 3;

    // event bits
    localparam int EV_TX_CLEARED = 0;
    localparam int EV_RX_CLEARED = 1;
    localparam int EV_ENABLE_CHANGED = 2;
    localparam int EV_IRQ_RAISED = 3;
    localparam int EV_WIDTH = 4;

    // ----------------------------------------------------------------
    // interrupt identification codes
    // ----------------------------------------------------------------
    localparam logic [3:0] IID_NONE = 4'h1;
    localparam logic [3:0] IID_TX_EMPTY = 4'h2;
    localparam logic [3:0] IID_RX_AVAILABLE = 4'h4;
    localparam logic [3:0] IID_LINE_STATUS = 4'h6;
    localparam logic [3:0] IID_BUSY_DETECT = 4'h7;
    localparam logic [3:0] IID_CHAR_TIMEOUT = 4'hc;
    localparam logic [3:0] IID_MODEM_STATUS = 4'h0;

    // ----------------------------------------------------------------
    // reset values and bus answers
    // ----------------------------------------------------------------
    localparam logic RST_DMA_MODE = 1'b0;
    localparam logic RST_FIFO_ENABLE = 1'b0;
    localparam logic [3:0] RST_SOURCE_ENABLE = 4'h0;
    localparam logic [EV_WIDTH-1:0] RST_EVENT = 4'h0;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// [verilog/uif_ident_enc.sv]
`timescale 1ns/1ps
module uif_ident_enc
    import uif_pkg::*;
(
    input wire logic line_status_pend,
    input wire logic rx_available_pend,
    input wire logic char_timeout_pend,
    input wire logic tx_empty_pend,
    input wire logic modem_status_pend,
    input wire logic busy_detect_pend,
    input wire logic [3:0] source_enable,
    input wire logic fifo_enable,
    output logic [3:0] code
);

    // ----------------------------------------------------------------
    // priority encode
    // ----------------------------------------------------------------
    // timeout only exists while the fifos run
    always_comb begin
        if (line_status_pend && source_enable[BIT_LINE_STATUS_EN]) begin
            code = IID_LINE_STATUS;
        end else if (rx_available_pend && source_enable[BIT_RX_AVAILABLE_EN]) begin
            code = IID_RX_AVAILABLE;
        end else if (char_timeout_pend && fifo_enable && source_enable[BIT_RX_AVAILABLE_EN]) begin
            code = IID_CHAR_TIMEOUT;
        end else if (tx_empty_pend && source_enable[BIT_TX_EMPTY_EN]) begin
            code = IID_TX_EMPTY;
        end else if (modem_status_pend && source_enable[BIT_MODEM_STATUS_EN]) begin
            code = IID_MODEM_STATUS;
        end else if (busy_detect_pend) begin
            code = IID_BUSY_DETECT;
        end else begin
            code = IID_NONE;
        end
    end

endmodule

// [dv/uif_ctrl_assertions.sv]
`timescale 1ns/1ps
module uif_ctrl_assertions
    import uif_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_bvalid,
    input wire logic line_status_pend,
    input wire logic rx_available_pend,
    input wire logic char_timeout_pend,
    input wire logic tx_empty_pend,
    input wire logic modem_status_pend,
    input wire logic busy_detect_pend,
    input wire logic dma_signal_mode,
    input wire logic fifo_enable_both,
    input wire logic tx_fifo_clear,
    input wire logic rx_fifo_clear,
    input wire logic [3:0] interrupt_ident_code
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic others;
    assign others = line_status_pend | rx_available_pend | char_timeout_pend | tx_empty_pend | modem_status_pend;
    // reset itself is the cause here, so this one is never disabled
    property p_reset_code; disable iff (1'b0) !aresetn |=> interrupt_ident_code == IID_NONE; endproperty
    a_reset_code: assert property (p_reset_code) else $error("code not none after reset");
    property p_idle_code; !others && !busy_detect_pend |=> interrupt_ident_code == IID_NONE; endproperty
    a_idle_code: assert property (p_idle_code) else $error("code not none when idle");
    property p_busy_code; !others && busy_detect_pend |=> interrupt_ident_code == IID_BUSY_DETECT; endproperty
    a_busy_code: assert property (p_busy_code) else $error("busy code wrong");
    property p_tx_pulse; tx_fifo_clear |=> !tx_fifo_clear; endproperty
    a_tx_pulse: assert property (p_tx_pulse) else $error("tx clear not self clearing");
    property p_rx_pulse; rx_fifo_clear |=> !rx_fifo_clear; endproperty
    a_rx_pulse: assert property (p_rx_pulse) else $error("rx clear not self clearing");
    property p_clear_on_write; (tx_fifo_clear || rx_fifo_clear) |-> s_axi_bvalid; endproperty
    a_clear_on_write: assert property (p_clear_on_write) else $error("clear without write");
    property p_enable_change; $past(aresetn) && $changed(fifo_enable_both) |-> tx_fifo_clear && rx_fifo_clear; endproperty
    a_enable_change: assert property (p_enable_change) else $error("enable change without clears");
    property p_dma_on_write; $past(aresetn) && $changed(dma_signal_mode) |-> s_axi_bvalid; endproperty
    a_dma_on_write: assert property (p_dma_on_write) else $error("dma mode moved without write");
endmodule

// [dv/uif_ctrl_bench.sv]
`timescale 1ns/1ps
module uif_ctrl_bench;
    import uif_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 4'hf;
    logic [5:0] pend = 0;
    logic awready, wready, bvalid, arready, rvalid, dma, fen, txc, rxc, irq;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd_val;
    logic [3:0] code;
    int errors = 0, tests_run = 0, ntx = 0, nrx = 0;
    // pend order: line, rx, timeout, tx empty, modem, busy
    logic [9:0] rows [12] = '{{6'h00, 4'h1}, {6'h01, 4'h7}, {6'h02, 4'h0}, {6'h04, 4'h2}, {6'h08, 4'hc},
        {6'h10, 4'h4}, {6'h20, 4'h6}, {6'h3f, 4'h6}, {6'h1f, 4'h4}, {6'h0f, 4'hc}, {6'h07, 4'h2}, {6'h03, 4'h0}};

    uif_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .line_status_pend(pend[5]), .rx_available_pend(pend[4]),
        .char_timeout_pend(pend[3]), .tx_empty_pend(pend[2]), .modem_status_pend(pend[1]),
        .busy_detect_pend(pend[0]), .dma_signal_mode(dma), .fifo_enable_both(fen), .tx_fifo_clear(txc),
        .rx_fifo_clear(rxc), .interrupt_ident_code(code), .irq(irq));

    // ------------------------------------------------------------
    // clock, pulse counters, watchdog
    // ------------------------------------------------------------
    initial forever #10 aclk = ~aclk;
    // counted mid-cycle so the totals are settled before the next rising edge
    always @(negedge aclk) begin
        if (txc === 1'b1) ntx++;
        if (rxc === 1'b1) nrx++;
    end
    initial begin
        #200us;
        errors++;
        conclude();
    end

    task automatic conclude();
        if (errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ------------------------------------------------------------
    // bus tasks: handshakes judged at the falling edge, acted on at the rising
    // ------------------------------------------------------------
    // local flags, not the valids: a valid set by <= still reads old in this step
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb, da, dw;
        ta = 0;
        tw = 0;
        tb = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        while (!(ta && tw)) begin
            @(negedge aclk);
            da = !ta && awready;
            dw = !tw && wready;
            @(posedge aclk);
            if (da) awvalid <= 0;
            if (dw) wvalid <= 0;
            ta = ta || da;
            tw = tw || dw;
        end
        bready <= 1;
        while (!tb) begin
            @(negedge aclk);
            tb = bvalid;
            resp = bresp;
            @(posedge aclk);
            if (tb) bready <= 0;
        end
    endtask

    task automatic rd(input logic [7:0] a);
        logic ta, tr;
        ta = 0;
        tr = 0;
        araddr <= a;
        arvalid <= 1;
        while (!ta) begin
            @(negedge aclk);
            ta = arready;
            @(posedge aclk);
            if (ta) arvalid <= 0;
        end
        rready <= 1;
        while (!tr) begin
            @(negedge aclk);
            tr = rvalid;
            rd_val = rdata;
            resp = rresp;
            @(posedge aclk);
            if (tr) rready <= 0;
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        chk(32'(code), 32'(IID_NONE));
        rd(ADDR_IRQ_IDENT_FIFO_CONTROL);
        chk(rd_val, 32'h1);
        wr(ADDR_IRQ_SOURCE_ENABLE, 32'hf);
        wr(ADDR_IRQ_IDENT_FIFO_CONTROL, 32'h9);
        chk(32'({fen, dma, 6'(ntx), 6'(nrx)}), 32'({2'b11, 6'd1, 6'd1}));
        for (int i = 0; i < 12; i++) begin
            pend <= rows[i][9:4];
            repeat (3) @(posedge aclk);
            chk(32'(code), 32'(rows[i][3:0]));
            rd(ADDR_IRQ_IDENT_FIFO_CONTROL);
            chk(rd_val, {28'h0, rows[i][3:0]});
        end
        pend <= 0;
        // each write gives the expected dma, enable and pulse counts after it
        wr(ADDR_IRQ_IDENT_FIFO_CONTROL, 32'h9);
        chk(32'({fen, dma, 6'(ntx), 6'(nrx)}), 32'({2'b11, 6'd1, 6'd1}));
        wr(ADDR_IRQ_IDENT_FIFO_CONTROL, 32'h5);
        chk(32'({fen, dma, 6'(ntx), 6'(nrx)}), 32'({2'b10, 6'd2, 6'd1}));
        wr(ADDR_IRQ_IDENT_FIFO_CONTROL, 32'h3);
        chk(32'({fen, dma, 6'(ntx), 6'(nrx)}), 32'({2'b10, 6'd2, 6'd2}));
        // explicit clears and the enable change land in one pulse, not two
        wr(ADDR_IRQ_IDENT_FIFO_CONTROL, 32'he);
        chk(32'({fen, dma, 6'(ntx), 6'(nrx)}), 32'({2'b01, 6'd3, 6'd3}));
        rd(ADDR_IRQ_IDENT_FIFO_CONTROL);
        chk(rd_val, 32'h1);
        rd(ADDR_IRQ_IDENT_FIFO_CONTROL);
        chk(32'({6'(ntx), 6'(nrx)}), 32'({6'd3, 6'd3}));
        wr(8'h20, 32'h1);
        chk(32'(resp), 32'(RESP_SLVERR));
        rd(8'h24);
        chk(rd_val, 32'h0);
        chk(32'(resp), 32'(RESP_SLVERR));
        // events are pending but masked, so irq must stay low
        chk(32'(irq), 32'h0);
        wr(ADDR_EVENT_MASK, 32'h1);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h1);
        wr(ADDR_EVENT_STATUS, 32'hf);
        repeat (2) @(posedge aclk);
        chk(32'(irq), 32'h0);
        rd(ADDR_EVENT_STATUS);
        chk(rd_val, 32'h0);
        // mid-run reset: controls drop back, source enables clear so line status is masked
        pend <= 6'h20;
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        chk(32'({fen, dma, irq, code}), 32'({3'b000, IID_NONE}));
        aresetn <= 1;
        repeat (3) @(posedge aclk);
        chk(32'(code), 32'(IID_NONE));
        rd(ADDR_IRQ_IDENT_FIFO_CONTROL);
        chk(rd_val, 32'h1);
        // lane 0 not strobed: answered, but nothing moves
        wstrb <= 4'he;
        wr(ADDR_IRQ_IDENT_FIFO_CONTROL, 32'h7);
        chk(32'({fen, 6'(ntx), 6'(nrx)}), 32'({1'b0, 6'd3, 6'd3}));
        chk(32'(resp), 32'(RESP_OKAY));
        conclude();
    end
endmodule

bind uif_ctrl uif_ctrl_assertions chk_i (.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
    .line_status_pend(line_status_pend), .rx_available_pend(rx_available_pend),
    .char_timeout_pend(char_timeout_pend), .tx_empty_pend(tx_empty_pend), .modem_status_pend(modem_status_pend),
    .busy_detect_pend(busy_detect_pend), .dma_signal_mode(dma_signal_mode), .fifo_enable_both(fifo_enable_both),
    .tx_fifo_clear(tx_fifo_clear), .rx_fifo_clear(rx_fifo_clear), .interrupt_ident_code(interrupt_ident_code));
